// ===== pkg/pd_pkg.sv
// ==========================================================
// power-down control constants and types
package pd_pkg;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_ULTRA_DOWN = 8'h79;
  localparam logic [7:0] OP_RESUME = 8'hAB;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET_DEVICE = 8'h99;
  localparam logic [7:0] OP_TERMINATE = 8'hF0;
  localparam logic [7:0] OP_PROG_PAGE = 8'h02;
  localparam logic [7:0] OP_PROG_SEQ_A = 8'hAF;
  localparam logic [7:0] OP_PROG_SEQ_B = 8'hAD;
  localparam logic [7:0] OP_PROG_DUAL = 8'hA2;
  localparam logic [7:0] OP_PROG_QUAD = 8'h32;
  localparam logic [7:0] OP_PROG_OTP = 8'h9B;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_ERASE_CHIP_A = 8'h60;
  localparam logic [7:0] OP_ERASE_CHIP_B = 8'hC7;

  // ==========================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_SR3 = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SR4 = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PWR = 8'h08;
  localparam int SR3_HWRST_EN_BIT = 7;
  localparam int SR4_DEPTH_BIT = 7;
  localparam int SR4_PE_BIT = 5;
  localparam int SR4_EE_BIT = 4;
  localparam int PWR_STATE_LSB = 0;
  localparam int PWR_ARMED_BIT = 4;
  localparam int PWR_BUSY_BIT = 5;
  localparam int PWR_READY_BIT = 6;
  localparam logic SR3_HWRST_EN_RESET = 1'b0;
  localparam logic SR4_DEPTH_RESET = 1'b0;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int LIGHT_WAKE_NS = 3000;
  localparam int DEEP_WAKE_NS = 100000;

  // least time: round up, never below one cycle
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEEP,
    ST_ULTRA,
    ST_WAKE_LIGHT,
    ST_WAKE_DEEP
  } pd_state_type;

  typedef enum logic [1:0] {
    OPK_NONE,
    OPK_PROG,
    OPK_ERASE
  } op_kind_type;

  typedef struct packed {
    logic tag;
    logic [7:0] opcode;
    logic full_opcode;
    logic aligned;
  } frame_sum_type;

  function automatic logic is_program(input logic [7:0] op);
    return op == OP_PROG_PAGE || op == OP_PROG_SEQ_A ||
      op == OP_PROG_SEQ_B || op == OP_PROG_DUAL ||
      op == OP_PROG_QUAD || op == OP_PROG_OTP;
  endfunction

  function automatic logic is_erase(input logic [7:0] op);
    return op == OP_ERASE_4K || op == OP_ERASE_32K ||
      op == OP_ERASE_64K || op == OP_ERASE_CHIP_A ||
      op == OP_ERASE_CHIP_B;
  endfunction

endpackage

// ===== design/spi_frame_rx.sv
`timescale 1ns/100ps
// ==========================================================
// link-side frame receiver, clocked by the serial clock
module spi_frame_rx
  import pd_pkg::*;
(
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic presetn,
  output frame_sum_type sum
);

  typedef struct packed {
    logic [2:0] bitcnt;
    logic [6:0] shreg;
    logic started;
    logic got8;
  } rx_type;

  rx_type f_q;
  rx_type f_d;
  frame_sum_type s_q;
  frame_sum_type s_d;
  logic frame_rst_n;

  // the frame state clears while chip select is high, so no edge
  // outside a frame is ever needed
  assign frame_rst_n = presetn & ~cs_n;

  always_comb begin
    f_d = f_q;
    s_d = s_q;
    f_d.bitcnt = 3'(f_q.bitcnt + 3'd1);
    f_d.shreg = {f_q.shreg[5:0], mosi};
    f_d.started = 1'b1;
    f_d.got8 = f_q.got8 | (f_q.bitcnt == 3'd7);
    // new tag on the first edge of each frame
    if (!f_q.started) begin
      s_d.tag = ~s_q.tag;
    end
    if (!f_q.got8 && f_q.bitcnt == 3'd7) begin
      s_d.opcode = {f_q.shreg, mosi};
    end
    s_d.full_opcode = f_q.got8 | (f_q.bitcnt == 3'd7); // [R17]
    s_d.aligned = (f_q.bitcnt == 3'd7); // [R17]
  end

  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  // summary survives the end of frame; the pclk side reads it
  // only after the synchronised chip-select rise
  always_ff @(posedge sclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sum = s_q;

endmodule

// ===== design/flash_power_down_control.sv
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/100ps
// Contract
// [R1] B9h with depth select 1 enters deep sleep
// [R2] B9h with depth select 0 enters ultra sleep
// [R3] 79h always enters ultra sleep
// [R4] ABh leaves deep sleep without reset
// [R5] ABh in ultra sleep runs internal reset
// [R6] 66h then 99h leaves deep sleep
// [R7] 66h/99h never leaves ultra sleep
// [R8] F0h never leaves either sleep state
// [R9] chip select rise alone never wakes
// [R10] POR, JEDEC or pin reset wakes to idle
// [R11] host enables reset pin before sleeping
// [R12] host waits wake time before commands
// [R13] resets abort program/erase, full reset
// [R14] F0h halts program/erase, no reset
// [R15] deep wake keeps error flags, ultra clears
// [R16] sleep ignores others, serial out released
// [R17] commands act on byte-aligned frame end
module flash_power_down_control
  import pd_pkg::*;
#(
  parameter int LIGHT_NS = LIGHT_WAKE_NS,
  parameter int DEEP_NS = DEEP_WAKE_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic so_out,
  output logic so_oe,
  input wire logic reset_pin_n,
  input wire logic jedec_reset_req,
  input wire logic op_busy,
  input wire logic prog_err_evt,
  input wire logic erase_err_evt,
  output logic core_reset,
  output logic op_halt,
  output logic powered_down,
  output logic dev_ready
);

  // ==========================================================
  // timing
  localparam int LIGHT_CYC = ns_to_cycles(LIGHT_NS);
  localparam int DEEP_CYC = ns_to_cycles(DEEP_NS);
  localparam int WAKE_W = $clog2(DEEP_CYC + 1);
  localparam logic [WAKE_W-1:0] LIGHT_LOAD = WAKE_W'(LIGHT_CYC - 1);
  localparam logic [WAKE_W-1:0] DEEP_LOAD = WAKE_W'(DEEP_CYC - 1);

  // ==========================================================
  // state
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic rp_s1;
    logic rp_s2;
    logic jr_s1;
    logic jr_s2;
    logic jr_s3;
    logic tag_seen;
    pd_state_type state;
    logic [WAKE_W-1:0] wait_cnt;
    logic hw_rst_en;
    logic depth_sel;
    logic pe_flag;
    logic ee_flag;
    logic rst_armed;
    op_kind_type kind;
    logic core_reset;
    logic halt;
    logic powered_down;
    logic ready;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic so_out;
    logic so_oe;
  } ctl_type;

  localparam ctl_type CTL_RESET = '{
    cs_s1: 1'b1,
    cs_s2: 1'b1,
    cs_s3: 1'b1,
    rp_s1: 1'b1,
    rp_s2: 1'b1,
    jr_s1: 1'b0,
    jr_s2: 1'b0,
    jr_s3: 1'b0,
    tag_seen: 1'b0,
    state: ST_IDLE,
    wait_cnt: '0,
    hw_rst_en: SR3_HWRST_EN_RESET,
    depth_sel: SR4_DEPTH_RESET,
    pe_flag: 1'b0,
    ee_flag: 1'b0,
    rst_armed: 1'b0,
    kind: OPK_NONE,
    core_reset: 1'b1,
    halt: 1'b0,
    powered_down: 1'b0,
    ready: 1'b0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000,
    so_out: 1'b0,
    so_oe: 1'b0
  };

  ctl_type q;
  ctl_type n;
  frame_sum_type sum;

  // ==========================================================
  // link side
  spi_frame_rx u_rx (
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .presetn(presetn),
    .sum(sum)
  );

  // ==========================================================
  // control
  logic frame_end;
  logic cmd_ok;
  logic [7:0] op;
  logic pin_rst;
  logic jedec_rst;
  logic soft_rst;
  logic dev_rst;
  logic access;
  logic wr;
  logic mapped;
  logic [31:0] rdata;

  always_comb begin
    n = q;
    n.core_reset = 1'b0;
    n.halt = 1'b0;
    n.cs_s1 = cs_n;
    n.cs_s2 = q.cs_s1;
    n.cs_s3 = q.cs_s2;
    n.rp_s1 = reset_pin_n;
    n.rp_s2 = q.rp_s1;
    n.jr_s1 = jedec_reset_req;
    n.jr_s2 = q.jr_s1;
    n.jr_s3 = q.jr_s2;

    // the summary is stable here: its last sclk edge came before
    // chip select rose, and that rise took two flops to arrive
    frame_end = q.cs_s2 & ~q.cs_s3;
    op = sum.opcode;
    // a frame with no clocks keeps the old tag and does nothing
    cmd_ok = frame_end & (sum.tag != q.tag_seen) &
      sum.full_opcode & sum.aligned; // [R9] [R17]
    if (frame_end) begin
      n.tag_seen = sum.tag;
    end

    pin_rst = ~q.rp_s2 & q.hw_rst_en; // [R11]
    jedec_rst = q.jr_s2 & ~q.jr_s3;
    soft_rst = cmd_ok & (op == OP_RESET_DEVICE) & q.rst_armed &
      (q.state == ST_IDLE || q.state == ST_DEEP); // [R6] [R7]
    dev_rst = pin_rst | jedec_rst | soft_rst;

    unique case (q.state)
      ST_IDLE: begin
        if (cmd_ok) begin
          n.rst_armed = (op == OP_RESET_ENABLE);
          if (op == OP_POWER_DOWN && !op_busy) begin
            n.state = q.depth_sel ? ST_DEEP : ST_ULTRA; // [R1] [R2]
          end else if (op == OP_ULTRA_DOWN && !op_busy) begin
            n.state = ST_ULTRA; // [R3]
          end else if (op == OP_TERMINATE && op_busy) begin
            n.halt = 1'b1; // [R14]
            n.pe_flag = q.pe_flag | (q.kind == OPK_PROG);
            n.ee_flag = q.ee_flag | (q.kind == OPK_ERASE);
          end else if (is_program(op)) begin
            n.pe_flag = 1'b0;
            n.kind = OPK_PROG;
          end else if (is_erase(op)) begin
            n.ee_flag = 1'b0;
            n.kind = OPK_ERASE;
          end
        end
      end
      ST_DEEP: begin
        // only resume and the reset pair are heard here
        if (cmd_ok) begin
          n.rst_armed = (op == OP_RESET_ENABLE); // [R6] [R16]
          if (op == OP_RESUME) begin
            n.state = ST_WAKE_LIGHT; // [R4] [R15]
            n.wait_cnt = LIGHT_LOAD;
          end
        end
      end
      ST_ULTRA: begin
        // F0h and the reset pair fall through and are dropped
        if (cmd_ok && op == OP_RESUME) begin
          n.state = ST_WAKE_DEEP; // [R5] [R7] [R8] [R16]
          n.wait_cnt = DEEP_LOAD;
          n.core_reset = 1'b1;
          n.pe_flag = 1'b0; // [R15]
          n.ee_flag = 1'b0;
          n.kind = OPK_NONE;
        end
      end
      ST_WAKE_LIGHT, ST_WAKE_DEEP: begin
        // commands during recovery are dropped; the host must wait
        if (q.wait_cnt == '0) begin
          n.state = ST_IDLE; // [R12]
        end else begin
          n.wait_cnt = WAKE_W'(q.wait_cnt - 1'b1);
        end
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase

    if (!op_busy && q.kind != OPK_NONE && !cmd_ok) begin
      n.kind = OPK_NONE;
    end

    // error events win over a command's clear
    if (prog_err_evt) begin
      n.pe_flag = 1'b1;
    end
    if (erase_err_evt) begin
      n.ee_flag = 1'b1;
    end

    if (dev_rst) begin
      n.state = ST_IDLE; // [R10]
      n.wait_cnt = '0;
      n.core_reset = 1'b1; // [R13]
      n.halt = op_busy; // [R13]
      n.pe_flag = 1'b0;
      n.ee_flag = 1'b0;
      n.rst_armed = 1'b0;
      n.kind = OPK_NONE;
    end

    // ==========================================================
    // apb slave: one wait state, write lands when pready is seen
    mapped = (paddr == ADDR_SR3) || (paddr == ADDR_SR4) ||
      (paddr == ADDR_PWR);
    access = psel & penable & ~q.pready;
    wr = psel & penable & pwrite & q.pready & mapped;
    rdata = 32'h0000_0000;
    if (paddr == ADDR_SR3) begin
      rdata[SR3_HWRST_EN_BIT] = q.hw_rst_en;
    end else if (paddr == ADDR_SR4) begin
      rdata[SR4_DEPTH_BIT] = q.depth_sel;
      rdata[SR4_PE_BIT] = q.pe_flag;
      rdata[SR4_EE_BIT] = q.ee_flag;
    end else if (paddr == ADDR_PWR) begin
      rdata[PWR_STATE_LSB +: 3] = q.state;
      rdata[PWR_ARMED_BIT] = q.rst_armed;
      rdata[PWR_BUSY_BIT] = op_busy;
      rdata[PWR_READY_BIT] = q.ready;
    end
    n.pready = access;
    n.pslverr = access & ~mapped;
    n.prdata = (access && !pwrite) ? rdata : 32'h0000_0000;
    if (wr && paddr == ADDR_SR3) begin
      n.hw_rst_en = pwdata[SR3_HWRST_EN_BIT];
    end
    if (wr && paddr == ADDR_SR4) begin
      n.depth_sel = pwdata[SR4_DEPTH_BIT];
    end

    n.powered_down = (n.state == ST_DEEP) || (n.state == ST_ULTRA);
    n.ready = (n.state == ST_IDLE);
    // no read path lives here, so the output is never driven
    n.so_out = 1'b0;
    n.so_oe = 1'b0; // [R16]
  end

  // pce low freezes every pclk-side flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= CTL_RESET; // [R10] [R13]
    end else if (pce) begin
      q <= n;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign so_out = q.so_out;
  assign so_oe = q.so_oe;
  assign core_reset = q.core_reset;
  assign op_halt = q.halt;
  assign powered_down = q.powered_down;
  assign dev_ready = q.ready;

endmodule

// ===== testbench/pd_props.sv
`timescale 1ns/100ps
// ==========
// port-level checks for the power-down controller
module pd_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic so_oe,
  input wire logic cs_n,
  input wire logic reset_pin_n,
  input wire logic jedec_reset_req,
  input wire logic op_busy,
  input wire logic core_reset,
  input wire logic op_halt,
  input wire logic powered_down,
  input wire logic dev_ready
);
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;

  // ==========
  // quiet: no frame and no reset for a while, so nothing may wake
  always_comb begin
    if (!cs_n || !reset_pin_n || jedec_reset_req) begin
      quiet_d = 4'h0;
    end else if (quiet_q != 4'hF) begin
      quiet_d = quiet_q + 4'h1;
    end else begin
      quiet_d = quiet_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_q <= 4'h0;
    end else begin
      quiet_q <= quiet_d;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========
  // assertions
  AST_SO_OFF: assert property (!so_oe)
    else $error("serial out driven in power-down block");
  AST_EXCL: assert property (!(powered_down && dev_ready))
    else $error("ready while powered down");
  AST_APB_WAIT: assert property (
    psel && !penable |=> !pready ##1 pready)
    else $error("register answer not in second access cycle");
  AST_JEDEC: assert property (
    $rose(jedec_reset_req) |-> ##[1:8] core_reset)
    else $error("jedec reset gave no core reset");
  AST_RST_PULSE: assert property ($rose(core_reset) |=> !core_reset)
    else $error("core reset longer than one cycle");
  AST_RST_HALT: assert property (
    $rose(core_reset) |-> op_halt == $past(op_busy))
    else $error("reset did not abort running operation");
  AST_HALT_BUSY: assert property ($rose(op_halt) |-> $past(op_busy))
    else $error("halt without a running operation");
  AST_QUIET_HOLD: assert property (
    powered_down && quiet_q == 4'hF |=> powered_down)
    else $error("left power-down without a cause");
  AST_IDLE_HOLD: assert property (
    dev_ready && quiet_q == 4'hF |=> dev_ready)
    else $error("left idle without a frame");

  cover property ($rose(powered_down));
  cover property (op_halt && !core_reset);
  cover property (pslverr);
endmodule

bind flash_power_down_control pd_props pd_props_inst (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .so_oe, .cs_n, .reset_pin_n,
  .jedec_reset_req, .op_busy, .core_reset, .op_halt, .powered_down,
  .dev_ready);

// ===== testbench/spi_host_model.sv
`timescale 1ns/100ps
// ==========
// spi host, mode 0; its clock stands still between frames
module spi_host_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // n bits of op, msb first; op repeats past eight bits
  task automatic frame(input logic [7:0] op, input int n);
    int i;
    // offset keeps the link edges off the system clock edges
    #7;
    cs_n = 1'b0;
    for (i = 0; i < n; i++) begin
      mosi = op[7 - (i % 8)];
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    mosi = ~mosi;
    // long gap covers the act delay and either wake time
    #600;
  endtask
endmodule

// ===== testbench/flash_power_down_control_bench.sv
`timescale 1ns/100ps
module flash_power_down_control_bench;
  import pd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic pce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic reset_pin_n = 1'b1;
  logic jedec_reset_req = 1'b0;
  logic op_busy = 1'b0;
  logic prog_err_evt = 1'b0;
  logic erase_err_evt = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic pready, pslverr, sclk, cs_n, mosi, so_out, so_oe, rerr;
  logic core_reset, op_halt, powered_down, dev_ready;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_rst = 0;
  int n_halt = 0;
  int r0, h0;

  always #10 pclk = ~pclk;

  flash_power_down_control #(.LIGHT_NS(100), .DEEP_NS(200))
    flash_power_down_control_inst (.pclk, .presetn, .pce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sclk, .cs_n,
    .mosi, .so_out, .so_oe, .reset_pin_n, .jedec_reset_req, .op_busy,
    .prog_err_evt, .erase_err_evt, .core_reset, .op_halt, .powered_down,
    .dev_ready);
  spi_host_model spi_host_model_inst (.sclk, .cs_n, .mosi);

  // ==========
  // pulse counters; ceiling is several times the expected run
  always @(posedge pclk) begin
    cycles++;
    if (core_reset === 1'b1) n_rst++;
    if (op_halt === 1'b1) n_halt++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] e, input string m);
    comparisons++;
    if (got !== e) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the cycle ceiling ends a wait that never gets an answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat & m, e, "register read");
  endtask

  task st(input logic [31:0] e);
    rd(ADDR_PWR, e, 32'h0000_0007);
  endtask

  task f(input logic [7:0] op);
    spi_host_model_inst.frame(op, 8);
  endtask

  task wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========
  // tests
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_SR3, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(ADDR_SR4, 32'h0000_0000, 32'hFFFF_FFFF);
    apb(1'b1, ADDR_PWR, 32'hFFFF_FFFF);
    rd(ADDR_PWR, 32'h0000_0040, 32'hFFFF_FFFF);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk({31'h0000_0000, rerr}, 32'h0000_0001, "unmapped");
    $display("test registers done");
    f(OP_POWER_DOWN);
    st(32'h0000_0002);
    chk({29'h0000_0000, so_out, powered_down, dev_ready}, 32'h0000_0002,
      "sleep pins");
    f(OP_RESET_ENABLE);
    f(OP_RESET_DEVICE);
    f(OP_TERMINATE);
    st(32'h0000_0002);
    r0 = n_rst;
    f(OP_RESUME);
    st(32'h0000_0000);
    chk(n_rst - r0, 32'h0000_0001, "ultra wake reset");
    $display("test ultra done");
    apb(1'b1, ADDR_SR4, 32'h0000_0080);
    spi_host_model_inst.frame(OP_POWER_DOWN, 9);
    st(32'h0000_0000);
    f(OP_POWER_DOWN);
    st(32'h0000_0001);
    f(OP_ERASE_4K);
    f(OP_TERMINATE);
    st(32'h0000_0001);
    f(OP_RESET_ENABLE);
    f(OP_RESET_DEVICE);
    st(32'h0000_0000);
    $display("test deep done");
    f(OP_PROG_PAGE);
    f(OP_ERASE_4K);
    @(posedge pclk);
    prog_err_evt <= 1'b1;
    erase_err_evt <= 1'b1;
    @(posedge pclk);
    prog_err_evt <= 1'b0;
    erase_err_evt <= 1'b0;
    apb(1'b1, ADDR_SR4, 32'h0000_0080);
    f(OP_POWER_DOWN);
    r0 = n_rst;
    f(OP_RESUME);
    chk(n_rst - r0, 32'h0000_0000, "deep wake reset");
    rd(ADDR_SR4, 32'h0000_0030, 32'h0000_0030);
    f(OP_ULTRA_DOWN);
    st(32'h0000_0002);
    f(OP_RESUME);
    // an error pulse while the clock enable is low must be lost
    @(posedge pclk);
    pce <= 1'b0;
    prog_err_evt <= 1'b1;
    @(posedge pclk);
    pce <= 1'b1;
    prog_err_evt <= 1'b0;
    rd(ADDR_SR4, 32'h0000_0000, 32'h0000_0030);
    $display("test flags done");
    // busy before the opcode lands, else the kind is dropped at once
    @(posedge pclk);
    op_busy <= 1'b1;
    f(OP_PROG_PAGE);
    r0 = n_rst;
    h0 = n_halt;
    f(OP_TERMINATE);
    chk(n_halt - h0, 32'h0000_0001, "halt");
    chk(n_rst - r0, 32'h0000_0000, "halt reset");
    rd(ADDR_SR4, 32'h0000_0020, 32'h0000_0030);
    f(OP_RESET_ENABLE);
    f(OP_RESET_DEVICE);
    @(posedge pclk);
    op_busy <= 1'b0;
    chk(n_rst - r0, 32'h0000_0001, "abort reset");
    chk(n_halt - h0, 32'h0000_0002, "abort halt");
    $display("test busy done");
    apb(1'b1, ADDR_SR4, 32'h0000_0080);
    f(OP_POWER_DOWN);
    @(posedge pclk);
    jedec_reset_req <= 1'b1;
    repeat (4) @(posedge pclk);
    jedec_reset_req <= 1'b0;
    repeat (12) @(posedge pclk);
    st(32'h0000_0000);
    apb(1'b1, ADDR_SR3, 32'h0000_0080);
    f(OP_ULTRA_DOWN);
    @(posedge pclk);
    // short pulse: core reset stays high as long as the pin is held
    reset_pin_n <= 1'b0;
    @(posedge pclk);
    reset_pin_n <= 1'b1;
    repeat (12) @(posedge pclk);
    st(32'h0000_0000);
    $display("test resets done");
    wrap_up();
  end
endmodule
